// ---- hw/coad_consts.vh ----
`ifndef COAD_CONSTS_VH
`define COAD_CONSTS_VH

// Addressing mode codes on mode_sel
`define COAD_MODE_W          4
`define COAD_M_INHERENT      4'h0
`define COAD_M_IMMEDIATE     4'h1
`define COAD_M_DIR_SHORT     4'h2
`define COAD_M_DIR_LONG      4'h3
`define COAD_M_IDX_NONE      4'h4
`define COAD_M_IDX_SHORT     4'h5
`define COAD_M_IDX_LONG      4'h6
`define COAD_M_IND_SHORT     4'h7
`define COAD_M_IND_LONG      4'h8
`define COAD_M_INDX_SHORT    4'h9
`define COAD_M_INDX_LONG     4'ha
`define COAD_M_REL_DIRECT    4'hb
`define COAD_M_REL_INDIRECT  4'hc

// Instruction set size and grouping
`define COAD_INSTR_COUNT     7'h3f
`define COAD_GROUP_COUNT     4'hd
`define COAD_GROUP_W         4

// Instruction groups
`define COAD_G_LOAD          4'h0
`define COAD_G_STACK         4'h1
`define COAD_G_INCDEC        4'h2
`define COAD_G_COMPARE       4'h3
`define COAD_G_LOGIC         4'h4
`define COAD_G_BIT           4'h5
`define COAD_G_BIT_BRANCH    4'h6
`define COAD_G_ARITH         4'h7
`define COAD_G_SHIFT         4'h8
`define COAD_G_JUMP          4'h9
`define COAD_G_COND_BRANCH   4'ha
`define COAD_G_INTERRUPT     4'hb
`define COAD_G_FLAGS         4'hc

`endif

// ---- hw/coad_decode.v ----
// Function
// - An immediate instruction is the opcode plus one byte used directly as the operand.
// - Short direct fetches one address byte and reaches only 00 to FF.
// - Long direct fetches a two-byte address word and reaches the full 64 Kbyte space.
// - Indexed addresses are the unsigned sum of index X or Y and the instruction offset.
// - Indexed with no offset fetches no byte and uses the index alone, 00 to FF.
// - Short indexed adds a one-byte offset to the index, reaching up to 1FE.
// - Long indexed adds a two-byte offset word to the index over the 64 Kbyte space.
// - Indirect modes read a pointer at the address after the opcode, then the operand.
// - Short indirect reads a one-byte pointer from a one-byte address, reaching 00 to FF.
// - Long indirect and long indirect indexed read a two-byte pointer via a one-byte address.
// - Indirect indexed addresses are the unsigned sum of index and pointer from memory.
// - Short indirect indexed uses a byte pointer so the result reaches at most 1FE.
// - Relative mode changes the program counter by an 8-bit signed offset.
// - Relative direct takes the offset after the opcode; relative indirect reads it from memory.
// - The decoder covers 63 instructions in 13 functional groups.
`timescale 1ns/100ps
`include "coad_consts.vh"

module coad_decode (
    input  wire        clock,
    input  wire        rst,
    input  wire        start,
    input  wire [3:0]  mode_sel,
    input  wire        use_y,
    input  wire [3:0]  instr_group,
    input  wire [7:0]  index_x,
    input  wire [7:0]  index_y,
    input  wire [15:0] pc_in,
    output reg  [15:0] mem_addr_ff,
    output reg         mem_rd_ff,
    input  wire        mem_ack,
    input  wire [7:0]  mem_rdata,
    output reg  [2:0]  oper_len_ff,
    output reg  [15:0] ea_ff,
    output reg  [7:0]  imm_ff,
    output reg         imm_valid_ff,
    output reg         pc_valid_ff,
    output reg  [15:0] new_pc_ff,
    output reg         done_ff,
    output reg         busy_ff,
    output reg         group_err_ff
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'h0;
localparam ST_OP1  = 3'h1;
localparam ST_OP2  = 3'h2;
localparam ST_PTR1 = 3'h3;
localparam ST_PTR2 = 3'h4;
localparam ST_REL  = 3'h5;
localparam ST_DONE = 3'h6;

reg [2:0]  state_ff;
reg [2:0]  nxt_state;
reg [3:0]  mode_ff;
reg [7:0]  index_ff;
reg [15:0] fetch_pc_ff;
reg [15:0] base_pc_ff;
reg [7:0]  byte1_ff;
reg [7:0]  ptr_hi_ff;

reg [15:0] nxt_mem_addr;
reg        nxt_mem_rd;
reg [2:0]  nxt_oper_len;
reg [15:0] nxt_ea;
reg [7:0]  nxt_imm;
reg        nxt_imm_valid;
reg        nxt_pc_valid;
reg [15:0] nxt_new_pc;
reg        nxt_done;
reg [3:0]  nxt_mode;
reg [7:0]  nxt_index;
reg [15:0] nxt_fetch_pc;
reg [15:0] nxt_base_pc;
reg [7:0]  nxt_byte1;
reg [7:0]  nxt_ptr_hi;

wire [15:0] pc_next = fetch_pc_ff + 16'h0001;
// Index zero-extended; unsigned addition never wraps below 1FE for byte operands
wire [15:0] idx_w   = {8'h00, index_ff};
// Relative base is the address after the last instruction byte
wire [15:0] rel_sum = base_pc_ff + {{8{mem_rdata[7]}}, mem_rdata};

////////////////////////////////////////////////////////////////////////////////
// Operand byte count after the opcode for each mode
function [2:0] coad_len;
    input [3:0] m;
    begin
        case (m)
            `COAD_M_IMMEDIATE:    coad_len = 3'h1;
            `COAD_M_DIR_SHORT:    coad_len = 3'h1;
            `COAD_M_DIR_LONG:     coad_len = 3'h2;
            `COAD_M_IDX_SHORT:    coad_len = 3'h1;
            `COAD_M_IDX_LONG:     coad_len = 3'h2;
            `COAD_M_IND_SHORT:    coad_len = 3'h1;
            `COAD_M_IND_LONG:     coad_len = 3'h1;
            `COAD_M_INDX_SHORT:   coad_len = 3'h1;
            `COAD_M_INDX_LONG:    coad_len = 3'h1;
            `COAD_M_REL_DIRECT:   coad_len = 3'h1;
            `COAD_M_REL_INDIRECT: coad_len = 3'h1;
            // Unused codes behave as one-byte instructions with no operand
            default:              coad_len = 3'h0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
always @* begin
    nxt_state     = state_ff;
    nxt_mem_addr  = mem_addr_ff;
    nxt_mem_rd    = mem_rd_ff;
    nxt_oper_len  = oper_len_ff;
    nxt_ea        = ea_ff;
    nxt_imm       = imm_ff;
    nxt_imm_valid = imm_valid_ff;
    nxt_pc_valid  = pc_valid_ff;
    nxt_new_pc    = new_pc_ff;
    nxt_done      = 1'b0;
    nxt_mode      = mode_ff;
    nxt_index     = index_ff;
    nxt_fetch_pc  = fetch_pc_ff;
    nxt_base_pc   = base_pc_ff;
    nxt_byte1     = byte1_ff;
    nxt_ptr_hi    = ptr_hi_ff;
    case (state_ff)
        ST_IDLE: begin
            // The done cycle is already idle, so a start there is taken too
            if (start) begin
                nxt_mode      = mode_sel;
                nxt_index     = use_y ? index_y : index_x;
                nxt_oper_len  = coad_len(mode_sel);
                nxt_imm_valid = 1'b0;
                nxt_pc_valid  = 1'b0;
                nxt_fetch_pc  = pc_in + 16'h0001;
                nxt_base_pc   = pc_in + 16'h0001 + {13'h0000, coad_len(mode_sel)};
                if (mode_sel == `COAD_M_IDX_NONE) begin
                    nxt_ea    = {8'h00, use_y ? index_y : index_x};
                    nxt_state = ST_DONE;
                end else if (coad_len(mode_sel) == 3'h0) begin
                    nxt_ea    = 16'h0000;
                    nxt_state = ST_DONE;
                end else begin
                    nxt_mem_addr = pc_in + 16'h0001;
                    nxt_mem_rd   = 1'b1;
                    nxt_state    = ST_OP1;
                end
            end
        end
        ST_OP1: begin
            if (mem_ack) begin
                nxt_byte1 = mem_rdata;
                case (mode_ff)
                    `COAD_M_IMMEDIATE: begin
                        nxt_imm       = mem_rdata;
                        nxt_imm_valid = 1'b1;
                        nxt_mem_rd    = 1'b0;
                        nxt_state     = ST_DONE;
                    end
                    `COAD_M_DIR_SHORT: begin
                        nxt_ea     = {8'h00, mem_rdata};
                        nxt_mem_rd = 1'b0;
                        nxt_state  = ST_DONE;
                    end
                    `COAD_M_IDX_SHORT: begin
                        nxt_ea     = idx_w + {8'h00, mem_rdata};
                        nxt_mem_rd = 1'b0;
                        nxt_state  = ST_DONE;
                    end
                    `COAD_M_DIR_LONG, `COAD_M_IDX_LONG: begin
                        nxt_mem_addr = pc_next;
                        nxt_fetch_pc = pc_next;
                        nxt_state    = ST_OP2;
                    end
                    `COAD_M_REL_DIRECT: begin
                        nxt_new_pc   = rel_sum;
                        nxt_pc_valid = 1'b1;
                        nxt_mem_rd   = 1'b0;
                        nxt_state    = ST_DONE;
                    end
                    `COAD_M_REL_INDIRECT: begin
                        nxt_mem_addr = {8'h00, mem_rdata};
                        nxt_state    = ST_REL;
                    end
                    default: begin
                        // Pointer address is always one byte in page zero
                        nxt_mem_addr = {8'h00, mem_rdata};
                        nxt_state    = ST_PTR1;
                    end
                endcase
            end
        end
        ST_OP2: begin
            if (mem_ack) begin
                nxt_mem_rd = 1'b0;
                nxt_state  = ST_DONE;
                // High byte comes first in the word
                if (mode_ff == `COAD_M_IDX_LONG)
                    nxt_ea = {byte1_ff, mem_rdata} + idx_w;
                else
                    nxt_ea = {byte1_ff, mem_rdata};
            end
        end
        ST_PTR1: begin
            if (mem_ack) begin
                case (mode_ff)
                    `COAD_M_IND_SHORT: begin
                        nxt_ea     = {8'h00, mem_rdata};
                        nxt_mem_rd = 1'b0;
                        nxt_state  = ST_DONE;
                    end
                    `COAD_M_INDX_SHORT: begin
                        nxt_ea     = {8'h00, mem_rdata} + idx_w;
                        nxt_mem_rd = 1'b0;
                        nxt_state  = ST_DONE;
                    end
                    default: begin
                        // Pointer byte address wraps within page zero
                        nxt_ptr_hi   = mem_rdata;
                        nxt_mem_addr = {8'h00, byte1_ff + 8'h01};
                        nxt_state    = ST_PTR2;
                    end
                endcase
            end
        end
        ST_PTR2: begin
            if (mem_ack) begin
                nxt_mem_rd = 1'b0;
                nxt_state  = ST_DONE;
                if (mode_ff == `COAD_M_INDX_LONG)
                    nxt_ea = {ptr_hi_ff, mem_rdata} + idx_w;
                else
                    nxt_ea = {ptr_hi_ff, mem_rdata};
            end
        end
        // Offset byte read from page zero, then added like the direct form
        ST_REL: begin
            if (mem_ack) begin
                nxt_new_pc   = rel_sum;
                nxt_pc_valid = 1'b1;
                nxt_mem_rd   = 1'b0;
                nxt_state    = ST_DONE;
            end
        end
        ST_DONE: begin
            nxt_done  = 1'b1;
            nxt_state = ST_IDLE;
        end
        default: begin
            nxt_mem_rd = 1'b0;
            nxt_state  = ST_IDLE;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge clock or posedge rst) begin
    if (rst) begin
        state_ff     <= ST_IDLE;
        mem_addr_ff  <= 16'h0000;
        mem_rd_ff    <= 1'b0;
        oper_len_ff  <= 3'h0;
        ea_ff        <= 16'h0000;
        imm_ff       <= 8'h00;
        imm_valid_ff <= 1'b0;
        pc_valid_ff  <= 1'b0;
        new_pc_ff    <= 16'h0000;
        done_ff      <= 1'b0;
        busy_ff      <= 1'b0;
        group_err_ff <= 1'b0;
        mode_ff      <= 4'h0;
        index_ff     <= 8'h00;
        fetch_pc_ff  <= 16'h0000;
        base_pc_ff   <= 16'h0000;
        byte1_ff     <= 8'h00;
        ptr_hi_ff    <= 8'h00;
    end else begin
        state_ff     <= nxt_state;
        mem_addr_ff  <= nxt_mem_addr;
        mem_rd_ff    <= nxt_mem_rd;
        oper_len_ff  <= nxt_oper_len;
        ea_ff        <= nxt_ea;
        imm_ff       <= nxt_imm;
        imm_valid_ff <= nxt_imm_valid;
        pc_valid_ff  <= nxt_pc_valid;
        new_pc_ff    <= nxt_new_pc;
        done_ff      <= nxt_done;
        // Busy mirrors the state, so low busy means a start will be taken
        busy_ff      <= (nxt_state != ST_IDLE);
        mode_ff      <= nxt_mode;
        index_ff     <= nxt_index;
        fetch_pc_ff  <= nxt_fetch_pc;
        base_pc_ff   <= nxt_base_pc;
        byte1_ff     <= nxt_byte1;
        ptr_hi_ff    <= nxt_ptr_hi;
        // Only 13 groups exist; codes above flag the request as bad
        if (start && state_ff == ST_IDLE)
            group_err_ff <= (instr_group >= `COAD_GROUP_COUNT);
    end
end

endmodule // coad_decode

// ---- dv/coad_mem_model.sv ----
`timescale 1ns/100ps
module coad_mem_model (
    input  wire        clock,
    input  wire        rst,
    input  wire        slow,
    input  wire        mem_rd_ff,
    input  wire [15:0] mem_addr_ff,
    output reg         mem_ack,
    output wire [7:0]  mem_rdata
);
    reg  [1:0] wait_ff;
    reg  [7:0] last_ff;
    // Data bus shows the inverse outside an answer so a stale byte never matches
    assign mem_rdata = mem_ack ? last_ff : ~last_ff;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            wait_ff <= 2'h0;
            last_ff <= 8'h00;
        end else begin
            mem_ack <= 1'b0;
            if (mem_rd_ff && !mem_ack) begin
                if (slow && wait_ff != 2'h3) begin
                    wait_ff <= wait_ff + 2'h1;
                end else begin
                    mem_ack <= 1'b1;
                    last_ff <= mem_addr_ff[7:0] + 8'h40;
                    wait_ff <= 2'h0;
                end
            end
        end
    end
endmodule // coad_mem_model

// ---- dv/coad_decode_monitor.sv ----
`timescale 1ns/100ps
`include "coad_consts.vh"
module coad_decode_monitor (
    input wire        clock,
    input wire        rst,
    input wire        start,
    input wire [3:0]  mode_sel,
    input wire        use_y,
    input wire [3:0]  instr_group,
    input wire [7:0]  index_x,
    input wire [7:0]  index_y,
    input wire [15:0] pc_in,
    input wire [15:0] mem_addr_ff,
    input wire        mem_rd_ff,
    input wire [2:0]  oper_len_ff,
    input wire [15:0] ea_ff,
    input wire        imm_valid_ff,
    input wire        pc_valid_ff,
    input wire        done_ff,
    input wire        busy_ff,
    input wire        group_err_ff
);
    reg  [3:0]  mode_ff;
    reg  [15:0] pc_ff;
    reg  [7:0]  idx_ff;
    // Low busy is exactly the idle state, the done cycle included
    wire        take = start & ~busy_ff;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_ff <= 4'h0;
            pc_ff <= 16'h0000;
            idx_ff <= 8'h00;
        end else if (take) begin
            mode_ff <= mode_sel;
            pc_ff <= pc_in;
            idx_ff <= use_y ? index_y : index_x;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_imm_len: assert property (take && mode_sel == `COAD_M_IMMEDIATE |=> oper_len_ff == 3'h1)
        else $error("immediate length wrong");
    a_short_page: assert property (done_ff && mode_ff == `COAD_M_DIR_SHORT |-> ea_ff[15:8] == 8'h00)
        else $error("short direct left page zero");
    a_long_len: assert property (take && mode_sel == `COAD_M_DIR_LONG |=> oper_len_ff == 3'h2)
        else $error("long direct length wrong");
    a_idx_none: assert property (take && mode_sel == `COAD_M_IDX_NONE |=> ##[0:2] done_ff && ea_ff == {8'h00, idx_ff})
        else $error("no offset index address wrong");
    a_idx_reach: assert property (done_ff && mode_ff == `COAD_M_IDX_SHORT |-> ea_ff <= 16'h01fe)
        else $error("short index beyond 1fe");
    a_ptr_addr: assert property ($rose(mem_rd_ff) |-> mem_addr_ff == pc_ff + 16'h0001)
        else $error("first fetch not after opcode");
    a_ind_page: assert property (done_ff && mode_ff == `COAD_M_IND_SHORT |-> ea_ff[15:8] == 8'h00)
        else $error("short indirect left page zero");
    a_indx_reach: assert property (done_ff && mode_ff == `COAD_M_INDX_SHORT |-> ea_ff <= 16'h01fe)
        else $error("short indirect index beyond 1fe");
    a_group_err: assert property (take |=> group_err_ff == ($past(instr_group) > 4'hc))
        else $error("group error flag wrong");
    a_rel_flag: assert property (done_ff && (mode_ff == `COAD_M_REL_DIRECT || mode_ff == `COAD_M_REL_INDIRECT) |-> pc_valid_ff && !imm_valid_ff)
        else $error("relative target flag wrong");
    c_long_ind: cover property (take && mode_sel == `COAD_M_IND_LONG);
    c_rel_done: cover property (done_ff && pc_valid_ff);
    c_grp_err: cover property (group_err_ff);
endmodule // coad_decode_monitor
bind coad_decode coad_decode_monitor u_mon (
    .clock        (clock),
    .rst          (rst),
    .start        (start),
    .mode_sel     (mode_sel),
    .use_y        (use_y),
    .instr_group  (instr_group),
    .index_x      (index_x),
    .index_y      (index_y),
    .pc_in        (pc_in),
    .mem_addr_ff  (mem_addr_ff),
    .mem_rd_ff    (mem_rd_ff),
    .oper_len_ff  (oper_len_ff),
    .ea_ff        (ea_ff),
    .imm_valid_ff (imm_valid_ff),
    .pc_valid_ff  (pc_valid_ff),
    .done_ff      (done_ff),
    .busy_ff      (busy_ff),
    .group_err_ff (group_err_ff)
);

// ---- dv/coad_decode_tb_top.sv ----
`timescale 1ns/100ps
`include "coad_consts.vh"
module coad_decode_tb_top;
    logic clock = 0, rst = 1, start = 0, use_y = 0, slow = 0;
    logic [3:0] mode_sel = 4'h0, instr_group = 4'h0;
    logic [7:0] index_x = 8'hf0, index_y = 8'h81;
    logic [15:0] pc_in = 16'h0000;
    wire [15:0] mem_addr_ff, ea_ff, new_pc_ff;
    wire [7:0] mem_rdata, imm_ff;
    wire [2:0] oper_len_ff;
    wire mem_rd_ff, mem_ack, imm_valid_ff, pc_valid_ff, done_ff, busy_ff, group_err_ff;
    int error_cnt = 0, n_compared = 0;
    // Operand bytes after the opcode, one row per mode code
    logic [2:0] lens [13] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h0, 3'h1, 3'h2, 3'h1, 3'h1, 3'h1,
                              3'h1, 3'h1, 3'h1};
    coad_decode dut (
        .clock        (clock),
        .rst          (rst),
        .start        (start),
        .mode_sel     (mode_sel),
        .use_y        (use_y),
        .instr_group  (instr_group),
        .index_x      (index_x),
        .index_y      (index_y),
        .pc_in        (pc_in),
        .mem_addr_ff  (mem_addr_ff),
        .mem_rd_ff    (mem_rd_ff),
        .mem_ack      (mem_ack),
        .mem_rdata    (mem_rdata),
        .oper_len_ff  (oper_len_ff),
        .ea_ff        (ea_ff),
        .imm_ff       (imm_ff),
        .imm_valid_ff (imm_valid_ff),
        .pc_valid_ff  (pc_valid_ff),
        .new_pc_ff    (new_pc_ff),
        .done_ff      (done_ff),
        .busy_ff      (busy_ff),
        .group_err_ff (group_err_ff)
    );
    coad_mem_model mem (
        .clock       (clock),
        .rst         (rst),
        .slow        (slow),
        .mem_rd_ff   (mem_rd_ff),
        .mem_addr_ff (mem_addr_ff),
        .mem_ack     (mem_ack),
        .mem_rdata   (mem_rdata)
    );
    initial forever #4 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    function [7:0] f(input [15:0] a);
        f = a[7:0] + 8'h40;
    endfunction
    function [15:0] expect_of(input [3:0] m, input [15:0] pc, input [7:0] ix);
        logic [7:0] b, c, q;
        b = f(pc + 16'h1);
        c = f(pc + 16'h2);
        q = f(b);
        case (m)
            `COAD_M_DIR_LONG: expect_of = {b, c};
            `COAD_M_IDX_NONE: expect_of = {8'h00, ix};
            `COAD_M_IDX_SHORT: expect_of = {8'h00, b} + ix;
            `COAD_M_IDX_LONG: expect_of = {b, c} + ix;
            `COAD_M_IND_SHORT: expect_of = {8'h00, q};
            `COAD_M_IND_LONG: expect_of = {q, f(b + 8'h1)};
            `COAD_M_INDX_SHORT: expect_of = {8'h00, q} + ix;
            `COAD_M_INDX_LONG: expect_of = {q, f(b + 8'h1)} + ix;
            `COAD_M_REL_DIRECT: expect_of = pc + 16'h2 + {{8{b[7]}}, b};
            `COAD_M_REL_INDIRECT: expect_of = pc + 16'h2 + {{8{q[7]}}, q};
            default: expect_of = {8'h00, b};
        endcase
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task run(input [3:0] m, input [15:0] pc, input uy, input [3:0] g, input [2:0] len);
        logic [15:0] e;
        logic rel;
        int k;
        rel = m == `COAD_M_REL_DIRECT || m == `COAD_M_REL_INDIRECT;
        @(negedge clock);
        mode_sel = m;
        pc_in = pc;
        use_y = uy;
        instr_group = g;
        start = 1;
        @(negedge clock);
        start = 0;
        chk(oper_len_ff, len);
        chk(busy_ff, 1);
        for (k = 0; k < 60 && done_ff !== 1'b1; k++) @(negedge clock);
        e = expect_of(m, pc, uy ? index_y : index_x);
        chk(done_ff, 1);
        chk(busy_ff, 0);
        chk(group_err_ff, g > 4'hc);
        chk(imm_valid_ff, m == `COAD_M_IMMEDIATE);
        chk(pc_valid_ff, rel);
        if (m == `COAD_M_IMMEDIATE) chk(imm_ff, e[7:0]);
        else if (rel) chk(new_pc_ff, e);
        else if (m != `COAD_M_INHERENT) chk(ea_ff, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clock);
        chk({busy_ff, done_ff, mem_rd_ff, ea_ff[12:0]}, 16'h0000);
        rst = 0;
        for (int i = 0; i < 13; i++) run(i[3:0], 16'h20b0 + {i[11:0], 4'h0}, i[0], i[3:0], lens[i]);
        // Slow memory with the word pointer straddling the page end
        slow = 1;
        run(`COAD_M_INDX_LONG, 16'h40be, 1, 4'h9, 3'h1);
        run(`COAD_M_IND_LONG, 16'h51be, 0, 4'h0, 3'h1);
        slow = 0;
        index_x = 8'hff;
        run(`COAD_M_IDX_SHORT, 16'h00be, 0, 4'h0, 3'h1);
        run(`COAD_M_IDX_LONG, 16'h00be, 0, 4'h0, 3'h2);
        run(`COAD_M_INDX_SHORT, 16'h33be, 0, 4'hc, 3'h1);
        run(`COAD_M_DIR_SHORT, 16'h0100, 0, 4'hd, 3'h1);
        run(`COAD_M_REL_DIRECT, 16'hfff0, 1, 4'hf, 3'h1);
        // Reset in the middle of the address byte fetch after the opcode
        @(negedge clock);
        mode_sel = `COAD_M_IND_LONG;
        start = 1;
        @(negedge clock);
        start = 0;
        @(negedge clock);
        rst = 1;
        @(negedge clock);
        chk({busy_ff, mem_rd_ff, done_ff}, 16'h0000);
        rst = 0;
        run(`COAD_M_IND_SHORT, 16'h0210, 0, 4'h1, 3'h1);
        end_of_test;
    end
    initial begin
        #20000;
        error_cnt++;
        end_of_test;
    end
endmodule // coad_decode_tb_top
